// [dmx_pkg.sv]
// Package with register layout, modes and carriers for the diagnostic output mux control.
package dmx_pkg;

  // Register width and reset value.
  localparam int DATA_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Field positions within the diagnostic control register.
  localparam int EN_BIT = 7;
  localparam int SDO_BIT = 6;
  localparam int LVL_BIT = 5;
  localparam int ICS_HI = 4;
  localparam int ICS_LO = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;

  // Interconnect selection codes.
  localparam logic [2:0] ICS_NONE = 3'h0;
  localparam logic [2:0] ICS_ERR = 3'h1;
  localparam logic [2:0] ICS_CS = 3'h2;
  localparam logic [2:0] ICS_SDI = 3'h3;
  localparam logic [2:0] ICS_SCK = 3'h4;
  localparam logic [2:0] ICS_SDO = 3'h7;

  // Diagnostic mux modes.
  typedef enum logic [1:0] {
    DMX_FORCE = 2'h0,
    DMX_DIGITAL = 2'h1,
    DMX_ANALOG = 2'h2,
    DMX_ICONN = 2'h3
  } dmx_mode_t;

  // Decoded view of the control register.
  typedef struct packed {
    logic diag_output_pin_enable;
    logic sdo_force_level;
    logic pin_force_level;
    logic [2:0] interconnect_select;
    dmx_mode_t diag_mode_select;
  } dmx_ctrl_t;

  // Input pins looped back in interconnect test.
  typedef struct packed {
    logic err_in;
    logic cs_in;
    logic sdi_in;
    logic sck_in;
  } dmx_pins_t;

endpackage

// [dmx_diag_control.sv]
// Diagnostic output mux control register and pin routing.
`timescale 1ns/1ps

module dmx_diag_control #(
  parameter int CH_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic dev_reset_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic control_write_lock_in,
  input wire logic [CH_W-1:0] channel_select_in,
  input wire dmx_pkg::dmx_pins_t pins_in,
  input wire logic digital_mux_in,
  input wire logic analog_mux_active_in,
  output logic [7:0] rd_data_out,
  output logic diag_output_pin_out,
  output logic diag_output_pin_oe_out,
  output logic sdo_force_out,
  output logic sdo_force_oe_out,
  output logic [CH_W-1:0] channel_sel_out,
  output logic analog_route_en_out
);

  logic [7:0] ctrl_reg;
  dmx_pkg::dmx_ctrl_t ctrl;
  dmx_pkg::dmx_pins_t pins_meta_reg;
  dmx_pkg::dmx_pins_t pins_sync_reg;
  logic dig_meta_reg;
  logic dig_sync_reg;
  logic src_next;
  logic drive_next;
  logic sdo_drive_next;

  // Decodes an interconnect code into the looped-back pin level.
  function automatic logic iconn_pick(input logic [2:0] code, input dmx_pkg::dmx_pins_t p);
    logic v;
    v = 1'b0;
    case (code)
      dmx_pkg::ICS_ERR: v = p.err_in;
      dmx_pkg::ICS_CS: v = p.cs_in;
      dmx_pkg::ICS_SDI: v = p.sdi_in;
      dmx_pkg::ICS_SCK: v = p.sck_in;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  assign ctrl = dmx_pkg::dmx_ctrl_t'(ctrl_reg);

  // Control register: cleared by either reset, written only when unlocked.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || dev_reset_in) begin
      ctrl_reg <= dmx_pkg::CTRL_RESET;
    end else if (wr_strobe_in && !control_write_lock_in) begin
      ctrl_reg <= wr_data_in;
    end
  end

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      dig_meta_reg <= 1'b0;
      dig_sync_reg <= 1'b0;
    end else begin
      pins_meta_reg <= pins_in;
      pins_sync_reg <= pins_meta_reg;
      dig_meta_reg <= digital_mux_in;
      dig_sync_reg <= dig_meta_reg;
    end
  end

  // Selects the diagnostic source from the mode field.
  always_comb begin
    src_next = 1'b0;
    drive_next = ctrl.diag_output_pin_enable;
    case (ctrl.diag_mode_select)
      dmx_pkg::DMX_FORCE: src_next = ctrl.pin_force_level;
      dmx_pkg::DMX_DIGITAL: src_next = dig_sync_reg;
      dmx_pkg::DMX_ANALOG: begin
        src_next = 1'b0;
        drive_next = 1'b0; // The analog path owns the pin in this mode.
      end
      dmx_pkg::DMX_ICONN: src_next = iconn_pick(ctrl.interconnect_select, pins_sync_reg);
      default: src_next = 1'b0;
    endcase
    sdo_drive_next = ctrl.diag_output_pin_enable && (ctrl.diag_mode_select == dmx_pkg::DMX_ICONN)
      && (ctrl.interconnect_select == dmx_pkg::ICS_SDO) && pins_sync_reg.cs_in;
  end

  // Registered outputs so routing follows a write one cycle later.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      diag_output_pin_out <= 1'b0;
      diag_output_pin_oe_out <= 1'b0;
      sdo_force_out <= 1'b0;
      sdo_force_oe_out <= 1'b0;
      analog_route_en_out <= 1'b0;
    end else begin
      diag_output_pin_out <= drive_next ? src_next : 1'b0;
      diag_output_pin_oe_out <= drive_next;
      sdo_force_out <= sdo_drive_next ? ctrl.sdo_force_level : 1'b0;
      sdo_force_oe_out <= sdo_drive_next;
      analog_route_en_out <= ctrl.diag_output_pin_enable
        && (ctrl.diag_mode_select == dmx_pkg::DMX_ANALOG);
    end
  end

  // Channel selection passes only when the interconnect select field is ICS_NONE, in any mode.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      channel_sel_out <= '0;
    end else if (ctrl.interconnect_select == dmx_pkg::ICS_NONE) begin
      channel_sel_out <= channel_select_in;
    end else begin
      channel_sel_out <= '0;
    end
  end

  // Read-back of the stored register value.
  assign rd_data_out = ctrl_reg;

endmodule

// [dmx_host.sv]
// Host model that writes the diagnostic control register.
`timescale 1ns/1ps
module dmx_host (
  input wire logic ref_clk_in,
  output logic wr_strobe_in = 1'h0,
  output logic [7:0] wr_data_in = 8'h00
);
  // Sends one write pulse, then scrambles the released data lines.
  task wr(input logic [7:0] d);
    @(negedge ref_clk_in);
    wr_strobe_in = 1'h1;
    wr_data_in = d;
    @(negedge ref_clk_in);
    wr_strobe_in = 1'h0;
    wr_data_in = ~d;
  endtask
endmodule

// [dmx_chk.sv]
// Checker on the ports of the diagnostic output mux control.
`timescale 1ns/1ps
module dmx_chk #(
  parameter int CH_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic dev_reset_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic control_write_lock_in,
  input wire logic [CH_W-1:0] channel_select_in,
  input wire logic [7:0] rd_data_out,
  input wire logic diag_output_pin_out,
  input wire logic diag_output_pin_oe_out,
  input wire logic sdo_force_out,
  input wire logic sdo_force_oe_out,
  input wire logic [CH_W-1:0] channel_sel_out,
  input wire logic analog_route_en_out
);
  // All checks use the one clock and pause in reset.
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire [7:0] r = rd_data_out;
  wire w = wr_strobe_in && !dev_reset_in;
  a_float_off: assert property (!$past(r[7]) |-> !diag_output_pin_oe_out) else $error("oe on");
  a_force_lvl: assert property ($past(r[7] && r[1:0] == 2'h0)
    |-> diag_output_pin_oe_out && diag_output_pin_out == $past(r[5])) else $error("force level");
  a_analog_off: assert property ($past(r[7] && r[1:0] == 2'h2)
    |-> !diag_output_pin_oe_out && analog_route_en_out) else $error("analog mode");
  a_sdo_gate: assert property (sdo_force_oe_out
    |-> $past(r[7] && r[4:0] == 5'h1f) && sdo_force_out == $past(r[6])) else $error("sdo");
  a_chan_gate: assert property ($past(rst_b_in)
    |-> channel_sel_out == ($past(r[4:2]) == 3'h0 ? $past(channel_select_in) : '0))
    else $error("channel");
  a_lock_hold: assert property (w && control_write_lock_in |=> $stable(r)) else $error("lock");
  a_write_take: assert property (w && !control_write_lock_in
    |=> r == $past(wr_data_in)) else $error("write");
  a_dev_clear: assert property (dev_reset_in |=> r == 8'h00) else $error("dev reset");
endmodule
bind dmx_diag_control dmx_chk #(.CH_W(CH_W)) i_dmx_chk (.*);

// [tb_top.sv]
// Self-checking bench for the diagnostic output mux control.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'h0, rst_b_in = 1'h0, dev_reset_in = 1'h0, control_write_lock_in = 1'h0;
  logic digital_mux_in = 1'h0, analog_mux_active_in = 1'h0, wr_strobe_in, diag_output_pin_out;
  logic diag_output_pin_oe_out, sdo_force_out, sdo_force_oe_out, analog_route_en_out;
  logic [7:0] wr_data_in, rd_data_out, channel_sel_out, channel_select_in = 8'h00;
  dmx_pkg::dmx_pins_t pins_in = 4'h0;
  int n_mismatch = 0, checked = 0, cyc = 0;
  // Rows hold the written byte, the pins, then the expected pin enable and level.
  logic [13:0] rows [12] = '{14'h2002, 14'h2803, 14'h0800, 14'h2080, 14'h2047, 14'h21e3,
    14'h22ee, 14'h23cb, 14'h24fa, 14'h20c2, 14'h25fe, 14'h26fe};
  always #2 ref_clk_in = ~ref_clk_in;
  dmx_diag_control i_dmx_diag_control (.*);
  dmx_host i_dmx_host (.ref_clk_in, .wr_strobe_in, .wr_data_in);
  // Compares one value with its expectation.
  task chk(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (e !== s) begin
      n_mismatch++;
      $display("mismatch %0s exp %h got %h", n, e, s);
    end
  endtask
  task report_and_stop;
    $display("checked %0d mismatched %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Stops a hung run.
  always @(posedge ref_clk_in) if (++cyc == 2000) begin
    n_mismatch++;
    report_and_stop;
  end
  // Table pass first, then lock, forced SDO, channel gating and device reset.
  initial begin
    repeat (6) @(negedge ref_clk_in);
    chk("rst", 8'h00, rd_data_out | channel_sel_out);
    chk("rst_oe", 8'h00, {6'h00, diag_output_pin_oe_out, sdo_force_oe_out});
    rst_b_in = 1'h1;
    foreach (rows[i]) begin
      pins_in = rows[i][5:2];
      digital_mux_in = rows[i][2];
      i_dmx_host.wr(rows[i][13:6]);
      repeat (4) @(negedge ref_clk_in);
      chk("rd", rows[i][13:6], rd_data_out);
      chk("pin", rows[i][1:0], {diag_output_pin_oe_out, diag_output_pin_out & diag_output_pin_oe_out});
    end
    $display("table test done");
    control_write_lock_in = 1'h1;
    i_dmx_host.wr(8'ha0);
    chk("lock", 8'h9b, rd_data_out);
    control_write_lock_in = 1'h0;
    pins_in = 4'h4;
    i_dmx_host.wr(8'hdf);
    repeat (4) @(negedge ref_clk_in);
    chk("sdo", 8'h0e, {sdo_force_oe_out, sdo_force_out, diag_output_pin_oe_out, diag_output_pin_out});
    pins_in = 4'h0;
    channel_select_in = 8'h5a;
    repeat (4) @(negedge ref_clk_in);
    chk("sdo_cs", 8'h00, {7'h00, sdo_force_oe_out});
    chk("chan_off", 8'h00, channel_sel_out);
    dev_reset_in = 1'h1;
    @(negedge ref_clk_in);
    dev_reset_in = 1'h0;
    chk("dev", 8'h00, rd_data_out);
    @(negedge ref_clk_in);
    chk("chan", 8'h5a, channel_sel_out);
    $display("hand tests done");
    report_and_stop;
  end
endmodule
